// ### hdl/ebspm_pin_mux.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

`include "ebspm_map.svh"

module ebspm_pin_mux
  import ebspm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // port zero pins
  input wire logic [7:0] port_zero_pins_level,
  output logic [7:0] port_zero_pins_drive,
  output logic [7:0] port_zero_pins_oe,
  output logic [7:0] port_zero_pins_pull,
  // port one pins
  input wire logic [7:0] port_one_pins_level,
  output logic [7:0] port_one_pins_drive,
  output logic [7:0] port_one_pins_oe,
  output logic [7:0] port_one_pins_pull,
  // port two pins
  input wire logic [7:0] port_two_pins_level,
  output logic [7:0] port_two_pins_drive,
  output logic [7:0] port_two_pins_oe,
  output logic [7:0] port_two_pins_pull,
  // port three pins: strobes and handshakes
  input wire logic [7:0] port_three_pins_level,
  output logic [7:0] port_three_pins_drive,
  output logic [7:0] port_three_pins_oe,
  output logic [7:0] port_three_pins_pull,
  // port four pins: first uart and serial inputs
  input wire logic [3:0] port_four_pins_level,
  output logic [3:0] port_four_pins_drive,
  output logic [3:0] port_four_pins_oe,
  // bus engine: address and data
  input wire logic [15:0] muxed_addr_data_out,
  input wire logic muxed_addr_data_oe,
  output logic [15:0] muxed_addr_data_in,
  input wire logic [7:0] upper_address_lines,
  // bus engine: strobes and clock
  input wire logic bus_ale,
  input wire logic bus_read_strobe,
  input wire logic bus_write_strobe,
  input wire logic bus_lane_low,
  input wire logic bus_lane_high,
  input wire logic bus_clock,
  // bus engine: hold and ready
  input wire logic bus_hold_acknowledge,
  output logic bus_hold_request,
  output logic bus_ready,
  output logic ext_bus_enabled,
  output logic bus_wide,
  // first uart
  input wire logic uart_a_serial_out,
  input wire logic uart_a_sout_en,
  input wire logic uart_a_serial_clock_out,
  input wire logic uart_a_sclk_en,
  output logic uart_a_serial_clock_in,
  output logic uart_a_serial_in,
  // second uart
  output logic uart_b_serial_in
);

  // layout of the flat pin vector
  localparam int NPIN = `EBSPM_PIN_COUNT;
  localparam int P3 = `EBSPM_PIN_P3;
  localparam int P4 = `EBSPM_PIN_P4;

  // registered state and its next value
  ebspm_state_t st_r;
  ebspm_state_t st_nxt;

  // per-pin views of function, port and cell
  logic [NPIN-1:0] pad_level;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] fn_sel;
  logic [NPIN-1:0] fn_out;
  logic [NPIN-1:0] fn_oe;
  logic [NPIN-1:0] gpio_out;
  logic [NPIN-1:0] gpio_dir;
  logic [NPIN-1:0] gpio_pull;
  logic [NPIN-1:0] cell_drive;
  logic [NPIN-1:0] cell_oe;
  logic [NPIN-1:0] cell_pull;
  logic ext_on;
  logic wrl_level;
  logic wrh_level;

  // pad levels gathered in pin order
  assign pad_level = {port_four_pins_level, port_three_pins_level,
                      port_two_pins_level, port_one_pins_level,
                      port_zero_pins_level};

  // every pad level is synchronised before use
  ebspm_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(pad_level),
    .sync_out(pin_sync)
  );

  assign ext_on = st_r.ctrl.ext_en;

  // write strobe lanes: 16-bit splits, 8-bit uses one lane
  always_comb begin
    if (st_r.ctrl.bus16) begin
      wrl_level = bus_write_strobe & bus_lane_low;
      wrh_level = bus_write_strobe & bus_lane_high;
    end else begin
      wrl_level = bus_write_strobe;
      wrh_level = 1'b0;
    end
  end

  // function selection for every shared pin
  always_comb begin
    fn_sel = '0;
    fn_out = '0;
    fn_oe = '0;
    // address/data bytes
    fn_sel[7:0] = {8{ext_on}};
    fn_out[7:0] = muxed_addr_data_out[7:0];
    fn_oe[7:0] = {8{muxed_addr_data_oe}};
    fn_sel[15:8] = {8{ext_on}};
    fn_out[15:8] = muxed_addr_data_out[15:8];
    fn_oe[15:8] = {8{muxed_addr_data_oe}};
    // upper address lines, per bit
    fn_sel[23:16] = {8{ext_on}} & ~st_r.uactl;
    fn_out[23:16] = upper_address_lines;
    fn_oe[23:16] = 8'hFF;
    // address latch and read strobe
    fn_sel[P3] = ext_on;
    fn_out[P3] = bus_ale;
    fn_oe[P3] = 1'b1;
    fn_sel[P3+1] = ext_on;
    fn_out[P3+1] = bus_read_strobe;
    fn_oe[P3+1] = 1'b1;
    // write strobes
    fn_sel[P3+2] = ext_on & st_r.ctrl.wrl_en;
    fn_out[P3+2] = wrl_level;
    fn_oe[P3+2] = 1'b1;
    fn_sel[P3+3] = ext_on & st_r.ctrl.bus16 & st_r.ctrl.wrh_en;
    fn_out[P3+3] = wrh_level;
    fn_oe[P3+3] = 1'b1;
    // hold request is an input, port driver stays off
    fn_sel[P3+4] = ext_on & st_r.ctrl.hold_en;
    fn_out[P3+4] = 1'b0;
    fn_oe[P3+4] = 1'b0;
    fn_sel[P3+5] = ext_on & st_r.ctrl.hold_en;
    fn_out[P3+5] = bus_hold_acknowledge;
    fn_oe[P3+5] = 1'b1;
    // ready is an input
    fn_sel[P3+6] = ext_on & st_r.ctrl.rdy_en;
    fn_out[P3+6] = 1'b0;
    fn_oe[P3+6] = 1'b0;
    fn_sel[P3+7] = ext_on & st_r.ctrl.clk_en;
    fn_out[P3+7] = bus_clock;
    fn_oe[P3+7] = 1'b1;
    // first uart data and clock
    fn_sel[P4] = uart_a_sout_en;
    fn_out[P4] = uart_a_serial_out;
    fn_oe[P4] = 1'b1;
    fn_sel[P4+1] = uart_a_sclk_en;
    fn_out[P4+1] = uart_a_serial_clock_out;
    fn_oe[P4+1] = 1'b1;
    // serial inputs never take the pin away from the port
    fn_sel[P4+3:P4+2] = 2'b00;
  end

  // general port values in pin order; port four has no pull-up
  assign gpio_out = {st_r.pdata[4][3:0], st_r.pdata[3], st_r.pdata[2],
                     st_r.pdata[1], st_r.pdata[0]};
  assign gpio_dir = {st_r.pdir[4][3:0], st_r.pdir[3], st_r.pdir[2],
                     st_r.pdir[1], st_r.pdir[0]};
  assign gpio_pull = {4'h0, st_r.ppull[3], st_r.ppull[2],
                      st_r.ppull[1], st_r.ppull[0]};

  // one cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_cell
      ebspm_pin_cell u_cell (
        .gpio_out(gpio_out[gi]),
        .gpio_dir(gpio_dir[gi]),
        .gpio_pull(gpio_pull[gi]),
        .fn_sel(fn_sel[gi]),
        .fn_out(fn_out[gi]),
        .fn_oe(fn_oe[gi]),
        .pad_drive(cell_drive[gi]),
        .pad_oe(cell_oe[gi]),
        .pad_pull(cell_pull[gi])
      );
    end
  endgenerate

  // register writes, read decode and pad registering
  always_comb begin
    logic [2:0] pidx;
    logic port_hit;
    logic [7:0] wbyte;
    pidx = reg_addr[6:4];
    port_hit = (reg_addr[7:4] < `EBSPM_PORT_COUNT);
    wbyte = reg_wdata[7:0];
    st_nxt = st_r;
    if (pidx == 3'h4) begin
      wbyte = wbyte & `EBSPM_P4_MASK;
    end
    // software writes
    if (reg_wr) begin
      if (port_hit) begin
        unique case (reg_addr[3:0])
          `EBSPM_OFS_DATA: st_nxt.pdata[pidx] = wbyte;
          `EBSPM_OFS_DIR: st_nxt.pdir[pidx] = wbyte;
          `EBSPM_OFS_PULL: st_nxt.ppull[pidx] = wbyte;
          default: ;
        endcase
      end else if (reg_addr == `EBSPM_ADDR_CTRL) begin
        st_nxt.ctrl = reg_wdata[`EBSPM_CTRL_WIDTH-1:0];
      end else if (reg_addr == `EBSPM_ADDR_UACTL) begin
        st_nxt.uactl = reg_wdata[7:0];
      end
    end
    // read data stands for the one cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (port_hit) begin
        unique case (reg_addr[3:0])
          `EBSPM_OFS_DATA: st_nxt.rdata[7:0] = st_r.pdata[pidx];
          `EBSPM_OFS_DIR: st_nxt.rdata[7:0] = st_r.pdir[pidx];
          `EBSPM_OFS_PULL: st_nxt.rdata[7:0] = st_r.ppull[pidx];
          `EBSPM_OFS_LEVEL: begin
            if (pidx == 3'h4) begin
              st_nxt.rdata[3:0] = pin_sync[P4+3:P4];
            end else begin
              st_nxt.rdata[7:0] = pin_sync[pidx*8 +: 8];
            end
          end
          default: ;
        endcase
      end else if (reg_addr == `EBSPM_ADDR_CTRL) begin
        st_nxt.rdata[`EBSPM_CTRL_WIDTH-1:0] = st_r.ctrl;
      end else if (reg_addr == `EBSPM_ADDR_UACTL) begin
        st_nxt.rdata[7:0] = st_r.uactl;
      end else if (reg_addr == `EBSPM_ADDR_OWN_LO) begin
        st_nxt.rdata = fn_sel[31:0];
      end else if (reg_addr == `EBSPM_ADDR_OWN_HI) begin
        st_nxt.rdata[3:0] = fn_sel[NPIN-1:32];
      end
    end
    // pad outputs come from flip-flops
    st_nxt.drive = cell_drive;
    st_nxt.oe = cell_oe;
    st_nxt.pull = cell_pull;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r.pdata <= {5{`EBSPM_PORT_RST}};
      st_r.pdir <= {5{`EBSPM_PORT_RST}};
      st_r.ppull <= {5{`EBSPM_PORT_RST}};
      st_r.ctrl <= `EBSPM_CTRL_RST;
      st_r.uactl <= `EBSPM_UACTL_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.drive <= '0;
      st_r.oe <= '0;
      st_r.pull <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // register read port
  assign reg_rdata = st_r.rdata;

  // port zero pads, straight from flip-flops
  assign port_zero_pins_drive = st_r.drive[7:0];
  assign port_zero_pins_oe = st_r.oe[7:0];
  assign port_zero_pins_pull = st_r.pull[7:0];

  // port one pads
  assign port_one_pins_drive = st_r.drive[15:8];
  assign port_one_pins_oe = st_r.oe[15:8];
  assign port_one_pins_pull = st_r.pull[15:8];

  // port two pads
  assign port_two_pins_drive = st_r.drive[23:16];
  assign port_two_pins_oe = st_r.oe[23:16];
  assign port_two_pins_pull = st_r.pull[23:16];

  // port three pads
  assign port_three_pins_drive = st_r.drive[31:24];
  assign port_three_pins_oe = st_r.oe[31:24];
  assign port_three_pins_pull = st_r.pull[31:24];

  // port four pads have no pull-up
  assign port_four_pins_drive = st_r.drive[NPIN-1:32];
  assign port_four_pins_oe = st_r.oe[NPIN-1:32];

  // synced address/data back to the bus engine
  assign muxed_addr_data_in = pin_sync[15:0];

  // hold and ready answer only when their function owns the pin
  assign bus_hold_request = fn_sel[P3+4] & pin_sync[P3+4];
  assign bus_ready = fn_sel[P3+6] ? pin_sync[P3+6] : 1'b1;

  // control bits the bus engine needs
  assign ext_bus_enabled = st_r.ctrl.ext_en;
  assign bus_wide = st_r.ctrl.bus16;

  // synced serial pins seen by the uarts
  assign uart_a_serial_clock_in = pin_sync[P4+1];
  assign uart_a_serial_in = pin_sync[P4+2];
  assign uart_b_serial_in = pin_sync[P4+3];

endmodule

`default_nettype wire

// ### hdl/ebspm_map.svh
`ifndef EBSPM_MAP_SVH
`define EBSPM_MAP_SVH

// register byte addresses, ports sit at a stride of 0x10
`define EBSPM_OFS_DATA 4'h0
`define EBSPM_OFS_DIR 4'h4
`define EBSPM_OFS_PULL 4'h8
`define EBSPM_OFS_LEVEL 4'hC
`define EBSPM_PORT_COUNT 4'h5
`define EBSPM_ADDR_CTRL 8'h50
`define EBSPM_ADDR_UACTL 8'h54
`define EBSPM_ADDR_OWN_LO 8'h58
`define EBSPM_ADDR_OWN_HI 8'h5C

// reset values and the port four write mask
`define EBSPM_CTRL_RST 7'h00
`define EBSPM_UACTL_RST 8'h00
`define EBSPM_PORT_RST 8'h00
`define EBSPM_P4_MASK 8'h0F

// bus control field positions
`define EBSPM_CTRL_EXT_EN 0
`define EBSPM_CTRL_BUS16 1
`define EBSPM_CTRL_WRL_EN 2
`define EBSPM_CTRL_WRH_EN 3
`define EBSPM_CTRL_HOLD_EN 4
`define EBSPM_CTRL_RDY_EN 5
`define EBSPM_CTRL_CLK_EN 6
`define EBSPM_CTRL_WIDTH 7

// pin indices in the flat pin vector
`define EBSPM_PIN_COUNT 36
`define EBSPM_PIN_P3 24
`define EBSPM_PIN_P4 32

`endif

// ### hdl/ebspm_pkg.sv
`include "ebspm_map.svh"

package ebspm_pkg;

  // bus function enables
  typedef struct packed {
    logic clk_en;
    logic rdy_en;
    logic hold_en;
    logic wrh_en;
    logic wrl_en;
    logic bus16;
    logic ext_en;
  } ebspm_ctrl_t;

  // whole state of the pin multiplexer
  typedef struct packed {
    logic [4:0][7:0] pdata;
    logic [4:0][7:0] pdir;
    logic [4:0][7:0] ppull;
    ebspm_ctrl_t ctrl;
    logic [7:0] uactl;
    logic [31:0] rdata;
    logic [`EBSPM_PIN_COUNT-1:0] drive;
    logic [`EBSPM_PIN_COUNT-1:0] oe;
    logic [`EBSPM_PIN_COUNT-1:0] pull;
  } ebspm_state_t;

endpackage

// ### hdl/ebspm_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ebspm_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ebspm_sync_st_t;

  ebspm_sync_st_t st_r;
  ebspm_sync_st_t st_nxt;

  // two stages, only the second one is read
  always_comb begin
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule

`default_nettype wire

// ### hdl/ebspm_pin_cell.sv
`timescale 1ns/1ns
`default_nettype none

module ebspm_pin_cell (
  // general port side
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic gpio_pull,
  // function side
  input wire logic fn_sel,
  input wire logic fn_out,
  input wire logic fn_oe,
  // pad side
  output logic pad_drive,
  output logic pad_oe,
  output logic pad_pull
);

  // owning function cuts off port driver and pull-up
  assign pad_drive = fn_sel ? fn_out : gpio_out;
  assign pad_oe = fn_sel ? fn_oe : gpio_dir;
  assign pad_pull = ~fn_sel & ~gpio_dir & gpio_pull;

endmodule

`default_nettype wire

// ### sim/ebspm_pin_mux_chk.sv
`timescale 1ns/1ns
`default_nettype none

module ebspm_pin_mux_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // bus engine side
  input wire logic ext_bus_enabled,
  input wire logic [15:0] muxed_addr_data_out,
  input wire logic muxed_addr_data_oe,
  input wire logic bus_ale,
  input wire logic bus_read_strobe,
  input wire logic bus_hold_request,
  input wire logic bus_ready,
  // pads
  input wire logic [7:0] port_zero_pins_drive,
  input wire logic [7:0] port_zero_pins_pull,
  input wire logic [7:0] port_one_pins_drive,
  input wire logic [7:0] port_one_pins_oe,
  input wire logic [7:0] port_three_pins_drive,
  input wire logic [7:0] port_three_pins_oe,
  input wire logic [7:0] port_three_pins_level,
  input wire logic [3:0] port_four_pins_drive,
  input wire logic [3:0] port_four_pins_oe,
  // first uart
  input wire logic uart_a_serial_out,
  input wire logic uart_a_sout_en,
  input wire logic uart_a_serial_clock_out,
  input wire logic uart_a_sclk_en
);
  // every check runs on the system clock and sleeps in reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  lo_bus_a: assert property (
    $past(ext_bus_enabled) |-> port_zero_pins_pull == 8'h00 &&
      port_zero_pins_drive == $past(muxed_addr_data_out[7:0]))
    else $error("low address/data pin wrong");
  hi_bus_a: assert property (
    $past(ext_bus_enabled) |->
      port_one_pins_oe == {8{$past(muxed_addr_data_oe)}} &&
      port_one_pins_drive == $past(muxed_addr_data_out[15:8]))
    else $error("high address/data pin wrong");
  latch_pin_a: assert property (
    $past(ext_bus_enabled) |->
      port_three_pins_oe[0] && port_three_pins_drive[0] == $past(bus_ale))
    else $error("latch enable pin wrong");
  read_pin_a: assert property (
    $past(ext_bus_enabled) |-> port_three_pins_oe[1] &&
      port_three_pins_drive[1] == $past(bus_read_strobe))
    else $error("read strobe pin wrong");
  hold_req_a: assert property (
    bus_hold_request |->
      ext_bus_enabled && $past(port_three_pins_level[4], 2))
    else $error("hold request without cause");
  ready_in_a: assert property (
    !bus_ready |-> ext_bus_enabled && !$past(port_three_pins_level[6], 2))
    else $error("ready low without cause");
  sout_pin_a: assert property (
    $past(uart_a_sout_en) |-> port_four_pins_oe[0] &&
      port_four_pins_drive[0] == $past(uart_a_serial_out))
    else $error("serial out pin wrong");
  sclk_pin_a: assert property (
    $past(uart_a_sclk_en) |-> port_four_pins_oe[1] &&
      port_four_pins_drive[1] == $past(uart_a_serial_clock_out))
    else $error("serial clock pin wrong");
endmodule

bind ebspm_pin_mux ebspm_pin_mux_chk u_chk (.*);

`default_nettype wire

// ### sim/ebspm_far_dev.sv
`timescale 1ns/1ns
`default_nettype none

module ebspm_far_dev (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // strobe and handshake pads
  input wire logic [7:0] pad_drive,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pull,
  output logic [7:0] pad_level,
  // behaviour controls
  input wire logic hold_want,
  input wire logic slow
);
  logic [1:0] stall_r;
  logic [7:0] flt_r;
  logic [7:0] far;

  // a slow device stretches a read by holding ready low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stall_r <= 2'h0;
      flt_r <= 8'h55;
    end else begin
      flt_r <= ~flt_r;
      if (slow && pad_oe[1] && pad_drive[1]) begin
        stall_r <= 2'h3;
      end else if (stall_r != 2'h0) begin
        stall_r <= stall_r - 2'h1;
      end
    end
  end

  // undriven lines float unless pulled up; hold and ready come from us
  always_comb begin
    far = pad_pull | (flt_r & ~pad_pull);
    far[4] = hold_want;
    far[6] = (stall_r == 2'h0);
    pad_level = (pad_oe & pad_drive) | (~pad_oe & far);
  end
endmodule

`default_nettype wire

// ### sim/ebspm_pin_mux_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (x)); end end

module ebspm_pin_mux_bench;
  // register port
  logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  // pads
  logic [7:0] port_zero_pins_level, port_zero_pins_drive, port_zero_pins_oe;
  logic [7:0] port_zero_pins_pull, port_one_pins_level, port_one_pins_drive;
  logic [7:0] port_one_pins_oe, port_one_pins_pull, port_two_pins_level;
  logic [7:0] port_two_pins_drive, port_two_pins_oe, port_two_pins_pull;
  logic [7:0] port_three_pins_level, port_three_pins_drive;
  logic [7:0] port_three_pins_oe, port_three_pins_pull;
  logic [3:0] port_four_pins_level, port_four_pins_drive, port_four_pins_oe;
  logic [7:0] lv0 = 8'h00, lv1 = 8'h00, lv2 = 8'h00;
  logic [3:0] lv4 = 4'h0;
  // bus engine and uarts
  logic [15:0] muxed_addr_data_out = 16'h0000, muxed_addr_data_in;
  logic [7:0] upper_address_lines = 8'h00;
  logic muxed_addr_data_oe = 1'b0, bus_ale = 1'b0, bus_read_strobe = 1'b0;
  logic bus_write_strobe = 1'b0, bus_lane_low = 1'b0, bus_lane_high = 1'b0;
  logic bus_clock = 1'b0, bus_hold_acknowledge = 1'b0;
  logic uart_a_serial_out = 1'b0, uart_a_sout_en = 1'b0;
  logic uart_a_serial_clock_out = 1'b0, uart_a_sclk_en = 1'b0;
  logic bus_hold_request, bus_ready, ext_bus_enabled, bus_wide;
  logic uart_a_serial_clock_in, uart_a_serial_in, uart_b_serial_in;
  logic hold_want = 1'b0, slow = 1'b0, e, w;
  // bench state
  int failures = 0, checks_done = 0;
  logic [15:0] seed = 16'h60ee, r;
  logic [7:0] pd [4], pr [4], pu [4], ua, own3, fn3;
  logic [6:0] ctrl;
  logic [6:0] corner [4] = '{7'h00, 7'h01, 7'h7f, 7'h7d};
  logic [3:0] pd4, pr4, o4, eo4, x4, lvl4;

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic logic [7:0] pad(input logic [7:0] o, dr, pl, lv);
    return (o & dr) | (~o & (pl | lv));
  endfunction

  ebspm_pin_mux uut (.*);
  ebspm_far_dev far (.clk_sys(clk_sys), .resetn(resetn),
    .pad_drive(port_three_pins_drive), .pad_oe(port_three_pins_oe),
    .pad_pull(port_three_pins_pull), .pad_level(port_three_pins_level),
    .hold_want(hold_want), .slow(slow));

  // pad wires: the device's drive wins, else pull-up, else the far pattern
  assign port_zero_pins_level = pad(port_zero_pins_oe, port_zero_pins_drive,
    port_zero_pins_pull, lv0);
  assign port_one_pins_level = pad(port_one_pins_oe, port_one_pins_drive,
    port_one_pins_pull, lv1);
  assign port_two_pins_level = pad(port_two_pins_oe, port_two_pins_drive,
    port_two_pins_pull, lv2);
  assign port_four_pins_level = (port_four_pins_oe & port_four_pins_drive) |
    (~port_four_pins_oe & lv4);

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task automatic port(input logic [7:0] go, gd, gu, own, ofn, fn,
    input int p);
    logic [7:0] eo;
    eo = (own & ofn) | (~own & pr[p]);
    `CHK(go, eo)
    `CHK(gd & eo, ((own & fn) | (~own & pd[p])) & eo)
    `CHK(gu, ~own & pu[p] & ~pr[p])
  endtask

  // expected pad view worked out from the control bits
  task automatic check();
    e = ctrl[0];
    w = ctrl[1];
    own3 = {e & ctrl[6], e & ctrl[5], {2{e & ctrl[4]}}, e & w & ctrl[3],
      e & ctrl[2], e, e};
    fn3 = {bus_clock, 1'b0, bus_hold_acknowledge, 1'b0,
      bus_write_strobe & bus_lane_high,
      w ? bus_write_strobe & bus_lane_low : bus_write_strobe,
      bus_read_strobe, bus_ale};
    port(port_zero_pins_oe, port_zero_pins_drive, port_zero_pins_pull,
      {8{e}}, {8{muxed_addr_data_oe}}, muxed_addr_data_out[7:0], 0);
    port(port_one_pins_oe, port_one_pins_drive, port_one_pins_pull,
      {8{e}}, {8{muxed_addr_data_oe}}, muxed_addr_data_out[15:8], 1);
    port(port_two_pins_oe, port_two_pins_drive, port_two_pins_pull,
      e ? ~ua : 8'h00, 8'hff, upper_address_lines, 2);
    port(port_three_pins_oe, port_three_pins_drive,
      port_three_pins_pull, own3, 8'haf, fn3, 3);
    o4 = {2'b00, uart_a_sclk_en, uart_a_sout_en};
    eo4 = o4 | pr4;
    x4 = (o4 & {2'b00, uart_a_serial_clock_out, uart_a_serial_out}) |
      (~o4 & pd4);
    lvl4 = (eo4 & x4) | (~eo4 & lv4);
    `CHK(port_four_pins_oe, eo4)
    `CHK(port_four_pins_drive & eo4, x4 & eo4)
    `CHK({uart_b_serial_in, uart_a_serial_in}, lv4[3:2])
    `CHK(uart_a_serial_clock_in, lvl4[1])
    `CHK(bus_hold_request, e & ctrl[4] & hold_want)
    `CHK(bus_ready, !(e & ctrl[5] & slow & bus_read_strobe))
    `CHK({bus_wide, ext_bus_enabled}, ctrl[1:0])
    `CHK(muxed_addr_data_in, {port_one_pins_level, port_zero_pins_level})
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(8'h50);
    `CHK(d, 32'h0000_0000)
    rd(8'h60);
    `CHK(d, 32'h0000_0000)
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      ctrl = (i < 4) ? corner[i] : r[6:0];
      ua = r[15:8];
      r = (i == 2) ? rnd() | 16'h102b : rnd();
      {bus_ale, bus_read_strobe, bus_write_strobe, bus_lane_low,
        bus_lane_high, bus_clock, bus_hold_acknowledge, uart_a_serial_out,
        uart_a_sout_en, uart_a_serial_clock_out, uart_a_sclk_en,
        muxed_addr_data_oe, hold_want, slow} <= r[13:0];
      muxed_addr_data_out <= rnd();
      r = rnd();
      upper_address_lines <= r[7:0];
      lv0 <= r[15:8];
      r = rnd();
      lv1 <= r[7:0];
      lv2 <= r[15:8];
      r = rnd();
      lv4 <= r[3:0];
      pd4 = {2'b00, r[5:4]};
      pr4 = {2'b00, r[7:6]};
      // port registers go out back to back
      for (int p = 0; p < 4; p++) begin
        r = rnd();
        pd[p] = r[7:0];
        pr[p] = r[15:8];
        r = rnd();
        pu[p] = r[7:0];
        wr(8'(p * 16), 32'(pd[p]));
        wr(8'(p * 16 + 4), 32'(pr[p]));
        wr(8'(p * 16 + 8), 32'(pu[p]));
      end
      wr(8'h40, 32'(pd4));
      wr(8'h44, 32'(pr4));
      wr(8'h50, 32'(ctrl));
      wr(8'h54, 32'(ua));
      reg_wr <= 1'b0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      check();
      @(posedge clk_sys);
      rd(8'h50);
      `CHK(d, 32'(ctrl))
      rd(8'h54);
      `CHK(d, 32'(ua))
      rd(8'h58);
      `CHK(d, {own3, e ? ~ua : 8'h00, {16{e}}})
      rd(8'h5c);
      `CHK(d, 32'(o4))
      rd(8'h4c);
      `CHK(d, 32'(lvl4))
    end
    summarize();
  end

  // watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule

`default_nettype wire
